// >>> tlsr_conv.sv
// conversion pacer: latches the converter code once per period
// assumes i_temp_code is on the i_clk domain, 0.0625 degree steps
`timescale 1ns/100ps
module tlsr_conv
  import tlsr_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_shutdown,
  input wire logic [12:0] i_temp_code,
  output tlsr_sample_t o_sample
);

  typedef struct packed {
    logic [21:0] cnt;
    tlsr_sample_t smp;
  } tlsr_conv_st_t;

  tlsr_conv_st_t s_r;
  tlsr_conv_st_t s_nxt;

  // counter stays parked in shutdown so no sample is produced
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.smp.done = 1'b0;
    if (i_shutdown)
    begin
      s_nxt.cnt = 22'h000000;
    end
    else if (s_r.cnt == 22'(CONV_CYCLES - 1))
    begin
      s_nxt.cnt = 22'h000000;
      s_nxt.smp.done = 1'b1;
      s_nxt.smp.code = i_temp_code;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 22'h000001;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_sample = s_r.smp;

  conv_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.cnt < 22'(CONV_CYCLES))
    else $error("conversion counter past its period");

endmodule : tlsr_conv

// >>> tlsr_host_model.sv
// two-wire host model: start, stop, byte and word transfers
// assumes i_sda is the resolved line with a pull-up behind it
`timescale 1ns/100ps
module tlsr_host_model
  import tlsr_pkg::*;
#(
  parameter logic [2:0] SA = 3'h5
)
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // bus clock idles high and only runs inside frames
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // a quarter bit is two system clocks, so one bit lasts 320 ns
  task automatic tick(input logic scl, input logic sda);
    repeat (2) @(posedge i_clk);
    o_scl <= scl;
    o_sda <= sda;
  endtask : tick

  // data moves only while the clock is low; sampled mid-high
  task automatic bit_io(input logic tx, output logic rx);
    tick(1'b0, tx);
    tick(1'b1, tx);
    repeat (2) @(posedge i_clk);
    rx = i_sda;
    tick(1'b0, tx);
  endtask : bit_io

  // releasing data first makes this also a repeated start
  task automatic start();
    tick(1'b0, 1'b1);
    tick(1'b1, 1'b1);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask : start

  task automatic stop();
    tick(1'b0, 1'b0);
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b1);
  endtask : stop

  // one byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
    output logic ack_rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack_rx);
  endtask : xfer

  // register traffic only, address straps at plain logic levels
  task automatic write_word(input logic [7:0] ptr, input logic [15:0] d, output logic ok);
    logic [7:0] rx;
    logic [3:0] a;
    start();
    xfer({DEV_ADDR_HI, SA, 1'b0}, 1'b1, rx, a[3]);
    xfer(ptr, 1'b1, rx, a[2]);
    xfer(d[15:8], 1'b1, rx, a[1]);
    xfer(d[7:0], 1'b1, rx, a[0]);
    stop();
    ok = (a == 4'h0);
  endtask : write_word

  // pointer write, repeated start, two bytes, nack ends the read
  task automatic read_word(input logic [7:0] ptr, output logic [15:0] d);
    logic [7:0] rx;
    logic a;
    start();
    xfer({DEV_ADDR_HI, SA, 1'b0}, 1'b1, rx, a);
    xfer(ptr, 1'b1, rx, a);
    start();
    xfer({DEV_ADDR_HI, SA, 1'b1}, 1'b1, rx, a);
    xfer(8'hFF, 1'b0, d[15:8], a);
    xfer(8'hFF, 1'b1, d[7:0], a);
    stop();
  endtask : read_word
endmodule : tlsr_host_model

// >>> tlsr_pkg.sv
// shared constants and carriers for the limit and status register block
// assumes a 25 MHz system clock and a two-wire host bus sampled on it
package tlsr_pkg;

  // register pointers
  localparam logic [7:0] REG_CAPABILITY = 8'h00;
  localparam logic [7:0] REG_UPPER = 8'h02;
  localparam logic [7:0] REG_LOWER = 8'h03;
  localparam logic [7:0] REG_CRIT = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h05;
  localparam logic [7:0] REG_MAKER = 8'h06;
  localparam logic [7:0] REG_PART = 8'h07;
  localparam logic [7:0] REG_RES = 8'h08;

  // field layout and reset values
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
  localparam logic [4:0] RES_RST = 5'h0F;
  localparam logic [12:0] RES_MASK_0P5 = 13'h1FF8;
  localparam logic [12:0] RES_MASK_0P25 = 13'h1FFC;
  localparam logic [12:0] RES_MASK_0P125 = 13'h1FFE;
  localparam logic [12:0] RES_MASK_0P0625 = 13'h1FFF;

  // identity words, values arbitrary
  localparam logic [15:0] MAKER_ID_DEF = 16'h0A5C;
  localparam logic [15:0] PART_ID_DEF = 16'h7101;
  // fixed upper address bits, value arbitrary
  localparam logic [3:0] DEV_ADDR_HI = 4'h3;

  // hysteresis in quarter-degree steps
  localparam logic signed [11:0] BAND_WIDTH_SELECT_OFF = 12'h000;
  localparam logic signed [11:0] BAND_WIDTH_SELECT_1P5 = 12'h006;
  localparam logic signed [11:0] BAND_WIDTH_SELECT_3 = 12'h00C;
  localparam logic signed [11:0] BAND_WIDTH_SELECT_6 = 12'h018;

  // conversion period: strictly under the longest conversion time
  localparam int CLK_HZ = 25_000_000;
  localparam int CONV_TIME_MS = 100;
  localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_HZ / 1000) - 1;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100
  } tlsr_bus_st_t;

  typedef enum logic [1:0]
  {
    PH_ADDR = 2'b00,
    PH_PTR = 2'b01,
    PH_MSB = 2'b10,
    PH_LSB = 2'b11
  } tlsr_phase_t;

  // loose control bits held outside this block
  typedef struct packed {
    logic critical_limit_lock;
    logic window_limit_lock;
    logic [1:0] band_width_select;
    logic shutdown;
    logic alarm_enable;
  } tlsr_ctrl_t;

  // one finished conversion
  typedef struct packed {
    logic done;
    logic [12:0] code;
  } tlsr_sample_t;

endpackage : tlsr_pkg

// >>> tlsr_top.sv
// limit, status and identity registers of the temperature sensor
// assumes scl, sda and address straps are asynchronous pins; the
// converter code and the control bits come from logic on i_clk
//
// How it works
// - lower limit at 03: sign bit 12, bits 11..2, others zero, reset zero
// - window event pulses on falling below lower minus band and again on rising back to lower limit
// - window lock makes the lower limit ignore writes
// - critical limit at 04, same encoding, resets to zero
// - alarm held while any of bits 15, 14 or 13 is set
// - critical lock makes the critical limit ignore writes
// - read-only temperature word at 05, two's complement, 0.0625 finest step
// - fraction bits finer than the selected resolution read zero
// - bit 15 set above critical, clears at critical minus band
// - bit 14 set above upper limit, clears at or below upper minus band
// - bit 13 set below lower minus band, clears at or above lower limit
// - fixed maker identifier word at 06
// - fixed word at 07: part type high byte, revision low byte
// - writable resolution register at 08, resets to 000F
// - bits 4-3 pick 0.5, 0.25, 0.125 or 0.0625 degree steps
// - resolution and bits 2-0 mirrored into the capability word
// - every conversion finishes in under 100 ms
// - three low address bits come from the select-address pins
// - band 00 off, 01 1.5, 10 3, 11 6 degrees on falling temperature
// - comparisons use only bits 12 through 2
// - lock bits clear only at reset; writing zero keeps them
`timescale 1ns/100ps
module tlsr_top
  import tlsr_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter logic [15:0] MAKER_ID = MAKER_ID_DEF,
  parameter logic [15:0] PART_ID = PART_ID_DEF
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_select_addr,
  input wire logic [12:0] i_temp_code,
  input tlsr_ctrl_t i_ctrl,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_alarm,
  output logic o_window_event
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [2:0] sa_m;
    logic [2:0] sa_s;
    tlsr_bus_st_t st;
    tlsr_phase_t ph;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] rdw;
    logic [7:0] wmsb;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic sda_oe_n;
    logic sda_o;
    logic [15:0] upper_lim;
    logic [15:0] low_lim;
    logic [15:0] crit_lim;
    logic [4:0] res;
    logic [12:0] raw;
    logic crit_flag;
    logic high_flag;
    logic low_flag;
    logic crit_lock;
    logic win_lock;
    logic alarm;
    logic evt;
  } tlsr_state_t;

  tlsr_state_t s_r;
  tlsr_state_t s_nxt;
  tlsr_sample_t smp;
  logic signed [11:0] t_w;
  logic signed [11:0] up_w;
  logic signed [11:0] lo_w;
  logic signed [11:0] cr_w;
  logic signed [11:0] h_w;
  logic [12:0] res_mask;
  logic [15:0] rd_w;
  logic conv_ok;

  // converter pacing lives in its own small block
  tlsr_conv #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_shutdown(i_ctrl.shutdown),
    .i_temp_code(i_temp_code),
    .o_sample(smp)
  );

  // comparison operands in quarter degrees, finer bits dropped
  assign t_w = {smp.code[12], smp.code[12:2]};
  assign up_w = {s_r.upper_lim[12], s_r.upper_lim[12:2]};
  assign lo_w = {s_r.low_lim[12], s_r.low_lim[12:2]};
  assign cr_w = {s_r.crit_lim[12], s_r.crit_lim[12:2]};
  assign conv_ok = smp.done & ~i_ctrl.shutdown;

  // band width and resolution decode
  always_comb
  begin
    case (i_ctrl.band_width_select)
      2'b01: h_w = BAND_WIDTH_SELECT_1P5;
      2'b10: h_w = BAND_WIDTH_SELECT_3;
      2'b11: h_w = BAND_WIDTH_SELECT_6;
      default: h_w = BAND_WIDTH_SELECT_OFF;
    endcase
    case (s_r.res[4:3])
      2'b00: res_mask = RES_MASK_0P5;
      2'b01: res_mask = RES_MASK_0P25;
      2'b10: res_mask = RES_MASK_0P125;
      default: res_mask = RES_MASK_0P0625;
    endcase
  end

  // read mux; the reading is masked at read time so a resolution
  // change takes effect without waiting for the next conversion
  always_comb
  begin
    case (s_r.ptr)
      REG_CAPABILITY: rd_w = {11'h000, s_r.res};
      REG_UPPER: rd_w = s_r.upper_lim;
      REG_LOWER: rd_w = s_r.low_lim;
      REG_CRIT: rd_w = s_r.crit_lim;
      REG_TEMP: rd_w = {s_r.crit_flag, s_r.high_flag, s_r.low_flag,
                        s_r.raw & res_mask};
      REG_MAKER: rd_w = MAKER_ID;
      REG_PART: rd_w = PART_ID;
      REG_RES: rd_w = {11'h000, s_r.res};
      default: rd_w = 16'h0000;
    endcase
  end

  // next state: synchronisers, bus engine, registers, flags, alarm
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.evt = 1'b0;
    s_nxt.sda_o = 1'b0;
    s_nxt.scl_m = i_scl;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_d = s_r.scl_s;
    s_nxt.sda_m = i_sda;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_d = s_r.sda_s;
    s_nxt.sa_m = i_select_addr;
    s_nxt.sa_s = s_r.sa_m;
    // locks only ever accumulate; reset is the sole way out
    s_nxt.crit_lock = s_r.crit_lock | i_ctrl.critical_limit_lock;
    s_nxt.win_lock = s_r.win_lock | i_ctrl.window_limit_lock;

    // start and stop win over any bit activity
    if (s_r.scl_s && s_r.scl_d && s_r.sda_d && !s_r.sda_s)
    begin
      s_nxt.st = ST_RECV;
      s_nxt.ph = PH_ADDR;
      s_nxt.bitc = 4'h0;
      s_nxt.sda_oe_n = 1'b1;
    end
    else if (s_r.scl_s && s_r.scl_d && !s_r.sda_d && s_r.sda_s)
    begin
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end
    else if (s_r.scl_s && !s_r.scl_d)
    begin
      // rising clock: sample
      case (s_r.st)
        ST_RECV:
        begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
          s_nxt.bitc = s_r.bitc + 4'h1;
        end
        ST_SEND: s_nxt.bitc = s_r.bitc + 4'h1;
        ST_MACK: s_nxt.nack = s_r.sda_s;
        default: s_nxt.bitc = s_r.bitc;
      endcase
    end
    else if (!s_r.scl_s && s_r.scl_d)
    begin
      // falling clock: drive and advance
      case (s_r.st)
        ST_RECV:
        begin
          if (s_r.bitc == 4'h8)
          begin
            s_nxt.sda_oe_n = 1'b0;
            s_nxt.st = ST_ACK;
            case (s_r.ph)
              PH_ADDR:
              begin
                if (s_r.sh[7:1] != {DEV_ADDR_HI, s_r.sa_s})
                begin
                  s_nxt.sda_oe_n = 1'b1;
                  s_nxt.st = ST_IDLE;
                end
                s_nxt.rw = s_r.sh[0];
              end
              PH_PTR: s_nxt.ptr = s_r.sh;
              PH_MSB: s_nxt.wmsb = s_r.sh;
              default:
              begin
                // word complete: locked limits silently keep their value
                case (s_r.ptr)
                  REG_UPPER:
                    if (!s_nxt.win_lock)
                      s_nxt.upper_lim = {s_r.wmsb, s_r.sh} & LIMIT_MASK;
                  REG_LOWER:
                    if (!s_nxt.win_lock)
                      s_nxt.low_lim = {s_r.wmsb, s_r.sh} & LIMIT_MASK;
                  REG_CRIT:
                    if (!s_nxt.crit_lock)
                      s_nxt.crit_lim = {s_r.wmsb, s_r.sh} & LIMIT_MASK;
                  REG_RES: s_nxt.res = s_r.sh[4:0];
                  default: s_nxt.res = s_r.res;
                endcase
              end
            endcase
          end
        end
        ST_ACK:
        begin
          s_nxt.sda_oe_n = 1'b1;
          s_nxt.bitc = 4'h0;
          s_nxt.st = ST_RECV;
          case (s_r.ph)
            PH_ADDR:
            begin
              if (s_r.rw)
              begin
                // word is snapshotted so both bytes belong together
                s_nxt.st = ST_SEND;
                s_nxt.ph = PH_MSB;
                s_nxt.sh = rd_w[15:8];
                s_nxt.rdw = rd_w[7:0];
                s_nxt.sda_oe_n = rd_w[15];
              end
              else
                s_nxt.ph = PH_PTR;
            end
            PH_PTR: s_nxt.ph = PH_MSB;
            PH_MSB: s_nxt.ph = PH_LSB;
            default: s_nxt.ph = PH_MSB;
          endcase
        end
        ST_SEND:
        begin
          if (s_r.bitc == 4'h8)
          begin
            s_nxt.sda_oe_n = 1'b1;
            s_nxt.st = ST_MACK;
          end
          else
          begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.sda_oe_n = s_r.sh[6];
          end
        end
        ST_MACK:
        begin
          s_nxt.bitc = 4'h0;
          if (s_r.nack)
            s_nxt.st = ST_IDLE;
          else if (s_r.ph == PH_MSB)
          begin
            s_nxt.st = ST_SEND;
            s_nxt.ph = PH_LSB;
            s_nxt.sh = s_r.rdw;
            s_nxt.sda_oe_n = s_r.rdw[7];
          end
          else
          begin
            s_nxt.st = ST_SEND;
            s_nxt.ph = PH_MSB;
            s_nxt.sh = rd_w[15:8];
            s_nxt.rdw = rd_w[7:0];
            s_nxt.sda_oe_n = rd_w[15];
          end
        end
        default: s_nxt.sda_oe_n = 1'b1;
      endcase
    end

    // flag evaluation once per finished conversion
    if (conv_ok)
    begin
      s_nxt.raw = smp.code;
      if (t_w > cr_w)
        s_nxt.crit_flag = 1'b1;
      else if (t_w <= cr_w - h_w)
        s_nxt.crit_flag = 1'b0;
      if (t_w > up_w)
        s_nxt.high_flag = 1'b1;
      else if (t_w <= up_w - h_w)
        s_nxt.high_flag = 1'b0;
      if (t_w < lo_w - h_w)
        s_nxt.low_flag = 1'b1;
      else if (t_w >= lo_w)
        s_nxt.low_flag = 1'b0;
    end
    // comparator-style alarm plus a pulse on each lower-window crossing
    s_nxt.alarm = i_ctrl.alarm_enable &
                  (s_nxt.crit_flag | s_nxt.high_flag | s_nxt.low_flag);
    s_nxt.evt = i_ctrl.alarm_enable & (s_nxt.low_flag ^ s_r.low_flag);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_r <= '0;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_d <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.sda_oe_n <= 1'b1;
      s_r.upper_lim <= LIMIT_RST;
      s_r.low_lim <= LIMIT_RST;
      s_r.crit_lim <= LIMIT_RST;
      s_r.res <= RES_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign o_sda = s_r.sda_o;
  assign o_sda_oe_n = s_r.sda_oe_n;
  assign o_alarm = s_r.alarm;
  assign o_window_event = s_r.evt;

  // checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  low_lock_hold_a: assert property (s_r.win_lock |=> $stable(s_r.low_lim))
    else $error("lower limit changed while locked");
  crit_lock_hold_a: assert property (s_r.crit_lock |=> $stable(s_r.crit_lim))
    else $error("critical limit changed while locked");
  lock_sticky_a: assert property ((s_r.crit_lock && s_r.win_lock)
    |=> (s_r.crit_lock && s_r.win_lock)[*3])
    else $error("a lock bit was released");
  low_unused_zero_a: assert property ((s_r.low_lim & ~LIMIT_MASK) == 16'h0000)
    else $error("unused lower limit bits nonzero");
  res_mask_read_a: assert property ((s_r.ptr == REG_TEMP && s_r.res[4:3] == 2'b00)
    |-> rd_w[2:0] == 3'h0)
    else $error("unsupported fraction bits visible");
  crit_set_a: assert property ((conv_ok && t_w > cr_w) |=> s_r.crit_flag)
    else $error("critical flag missed");
  high_set_a: assert property ((conv_ok && t_w > up_w) |=> s_r.high_flag)
    else $error("upper flag missed");
  low_clear_a: assert property ((conv_ok && t_w >= lo_w) |=> !s_r.low_flag)
    else $error("lower flag not cleared");
  crit_alarm_a: assert property ((s_r.crit_flag && $past(i_ctrl.alarm_enable))
    |-> o_alarm)
    else $error("alarm not asserted above critical");
  cap_mirror_a: assert property ((s_r.ptr == REG_CAPABILITY) |-> rd_w[4:0] == s_r.res)
    else $error("capability does not mirror resolution");
  shut_hold_a: assert property (i_ctrl.shutdown |=> $stable(s_r.raw))
    else $error("reading updated in shutdown");

  addr_ack_c: cover property (s_r.st == ST_RECV && s_r.ph == PH_ADDR ##1 s_r.st == ST_ACK);
  read_c: cover property (s_r.st == ST_SEND && s_r.ph == PH_LSB);
  crit_rise_c: cover property (!s_r.crit_flag ##1 s_r.crit_flag);
  locked_write_c: cover property (s_r.win_lock && s_r.st == ST_ACK && s_r.ph == PH_LSB);

endmodule : tlsr_top

// >>> tlsr_top_tb.sv
// self-checking bench for the limit and status registers
// assumes the host model owns the bus and sda has a pull-up
`timescale 1ns/100ps
module tlsr_top_tb;
  import tlsr_pkg::*;
  localparam int CONV = 50;
  logic i_clk, i_rst, host_scl, host_sda, sda_wire, ok;
  logic o_sda, o_sda_oe_n, o_alarm, o_window_event;
  logic alarm_line_n;
  logic [2:0] i_select_addr;
  logic [12:0] i_temp_code;
  logic [15:0] rd;
  tlsr_ctrl_t i_ctrl;
  int miscompares = 0;
  int samples_checked = 0;
  int win_events = 0;

  // open drain line: low when either side pulls
  assign sda_wire = host_sda & (o_sda_oe_n ? 1'b1 : o_sda);
  // host runs the alarm active low on a pulled-up shared line; only this part drives it
  assign alarm_line_n = ~o_alarm;

  tlsr_top #(.CONV_CYCLES(CONV)) tlsr_top_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_scl(host_scl), .i_sda(sda_wire), .i_select_addr(i_select_addr),
    .i_temp_code(i_temp_code), .i_ctrl(i_ctrl), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .o_alarm(o_alarm), .o_window_event(o_window_event));
  tlsr_host_model #(.SA(3'h5)) tlsr_host_model_inst (.i_clk(i_clk),
    .i_sda(sda_wire), .o_scl(host_scl), .o_sda(host_sda));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // one-cycle pulses are counted here so no task can miss them
  always @(posedge i_clk)
    if (o_window_event === 1'b1)
      win_events <= win_events + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    tlsr_host_model_inst.write_word(p, d, ok);
  endtask : wr

  task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
    tlsr_host_model_inst.read_word(p, rd);
    check(rd, e);
  endtask : rd_chk

  // two full conversion periods, so a fresh sample has landed
  task automatic temp(input logic [12:0] c);
    i_temp_code <= c;
    repeat (2 * CONV + 4) @(posedge i_clk);
  endtask : temp

  // flags are bits 15..13 of the reading; alarm is their enabled or
  task automatic step(input logic [12:0] c, input logic [2:0] f);
    temp(c);
    tlsr_host_model_inst.read_word(REG_TEMP, rd);
    check({13'h0000, rd[15:13]}, {13'h0000, f});
    check({15'h0000, o_alarm}, {15'h0000, |f & i_ctrl.alarm_enable});
    check({15'h0000, alarm_line_n}, {15'h0000, ~(|f & i_ctrl.alarm_enable)});
  endtask : step

  task automatic t_reset_values();
    rd_chk(REG_LOWER, LIMIT_RST);
    rd_chk(REG_CRIT, LIMIT_RST);
    rd_chk(REG_RES, {11'h000, RES_RST});
    rd_chk(REG_MAKER, MAKER_ID_DEF);
    rd_chk(REG_PART, PART_ID_DEF);
  endtask : t_reset_values

  // high limits keep the flags quiet while only the mask varies
  task automatic t_resolution();
    wr(REG_UPPER, 16'h0FFC);
    wr(REG_CRIT, 16'h0FFC);
    temp(13'h0ABF);
    for (int r = 0; r < 4; r++)
    begin
      wr(REG_RES, {11'h000, r[1:0], 3'b111});
      rd_chk(REG_RES, {11'h000, r[1:0], 3'b111});
      rd_chk(REG_CAPABILITY, {11'h000, r[1:0], 3'b111});
      rd_chk(REG_TEMP, {3'b000, 13'h0ABF & (13'h1FFF << (3 - r))});
    end
  endtask : t_resolution

  // upper 40, critical 80, lower 10 degrees with a 1.5 degree band
  task automatic t_window();
    int n;
    i_ctrl.band_width_select <= 2'b01;
    // settle right at the new upper limit first, so no hot flag carries in
    temp(13'h0280);
    wr(REG_UPPER, 16'h0280);
    wr(REG_CRIT, 16'h0500);
    wr(REG_LOWER, 16'h00A0);
    step(13'h0283, 3'b000);
    step(13'h0284, 3'b010);
    step(13'h026C, 3'b010);
    step(13'h0268, 3'b000);
    step(13'h0504, 3'b110);
    step(13'h04EC, 3'b110);
    step(13'h04E8, 3'b010);
    step(13'h0088, 3'b000);
    n = win_events;
    step(13'h0084, 3'b001);
    check(16'(win_events - n), 16'h0001);
    step(13'h009C, 3'b001);
    step(13'h00A0, 3'b000);
    check(16'(win_events - n), 16'h0002);
  endtask : t_window

  // critical clear point for each band code, then alarm off, then shutdown
  task automatic t_band();
    int h;
    wr(REG_UPPER, 16'h0FFC);
    for (int b = 0; b < 4; b++)
    begin
      i_ctrl.band_width_select <= b[1:0];
      h = (b == 0) ? 0 : (6 << (b - 1));
      step(13'h0504, 3'b100);
      step(13'((321 - h) * 4), 3'b100);
      step(13'((320 - h) * 4), 3'b000);
    end
    i_ctrl.alarm_enable <= 1'b0;
    step(13'h0504, 3'b100);
    i_ctrl.alarm_enable <= 1'b1;
    i_ctrl.shutdown <= 1'b1;
    temp(13'h0100);
    rd_chk(REG_TEMP, 16'h8504);
    i_ctrl.shutdown <= 1'b0;
    step(13'h0100, 3'b000);
  endtask : t_band

  task automatic t_limits();
    wr(REG_LOWER, 16'hFFFF);
    rd_chk(REG_LOWER, LIMIT_MASK);
    wr(REG_CRIT, 16'hFFFF);
    rd_chk(REG_CRIT, LIMIT_MASK);
    wr(REG_MAKER, 16'h1234);
    rd_chk(REG_MAKER, MAKER_ID_DEF);
    i_select_addr <= 3'h4;
    wr(REG_LOWER, 16'h0000);
    check({15'h0000, ok}, 16'h0000);
    i_select_addr <= 3'h5;
    rd_chk(REG_LOWER, LIMIT_MASK);
  endtask : t_limits

  // locks pulse briefly yet must stick until the next reset
  task automatic t_locks();
    i_ctrl.window_limit_lock <= 1'b1;
    i_ctrl.critical_limit_lock <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_ctrl.window_limit_lock <= 1'b0;
    i_ctrl.critical_limit_lock <= 1'b0;
    wr(REG_LOWER, 16'h0040);
    rd_chk(REG_LOWER, LIMIT_MASK);
    wr(REG_CRIT, 16'h0040);
    rd_chk(REG_CRIT, LIMIT_MASK);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd_chk(REG_CRIT, LIMIT_RST);
    wr(REG_LOWER, 16'h0040);
    rd_chk(REG_LOWER, 16'h0040);
  endtask : t_locks

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // about 28k cycles expected; this cuts a hung bus short
  initial
  begin
    #2400000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    i_rst = 1'b1;
    i_select_addr = 3'h5;
    i_temp_code = 13'h0000;
    i_ctrl = '0;
    i_ctrl.alarm_enable = 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    t_reset_values();
    t_resolution();
    t_window();
    t_band();
    t_limits();
    t_locks();
    report_and_stop();
  end
endmodule : tlsr_top_tb
